// >>> verilog/uart_line_map.svh
// Register map of the serial line control block.
`ifndef UART_LINE_MAP_SVH
`define UART_LINE_MAP_SVH
// ==========================================================================
// Register offsets.
`define ADDR_FRAME      4'h0
`define ADDR_HANDSHAKE  4'h1
`define ADDR_RESUME     4'h2
`define ADDR_PAUSE      4'h3
`define ADDR_LOOP       4'h4
`define ADDR_FAULT      4'h5
`define ADDR_BREAK      4'h6
`define ADDR_TURN       4'h7
`define ADDR_PINFUNC    4'h8
`define ADDR_PINDIR     4'h9
`define ADDR_PINMASK    4'hA
// ==========================================================================
// Field positions.
`define FRM_WIDTH       3:0
`define FRM_PAR         6:4
`define FRM_STOP2       7
`define HS_MODE         2:0
`define HS_HALF         3
`define LOOP_EN         2
`define FLT_BRK         3
`define FLT_FRM         4
`define FLT_PAR         5
`define FLT_OVR         6
`define FLT_LIVE        7
`define TURN_BITS       3:0
`define PF_CODE         2:0
`define PF_POL          3
`define PIN_BITS        5:0
// ==========================================================================
// Codes.
`define WIDTH_7         4'h7
`define WIDTH_8         4'h8
`define WIDTH_9         4'h9
`define PAR_NONE        3'h0
`define PAR_ODD         3'h1
`define PAR_EVEN        3'h2
`define PAR_MARK        3'h3
`define PAR_SPACE       3'h4
`define HS_NONE         3'h0
`define HS_HW           3'h1
`define HS_SW           3'h2
`define HS_DROP_RX      3'h3
`define HS_DROP_ALL     3'h4
`define PF_GPIO         3'h0
`define PF_RTSCTS       3'h1
`define PF_DTRDSR       3'h2
`define PF_DRV_TX       3'h3
`define PF_DRV_MATCH    3'h4
// ==========================================================================
// Reset values.
`define RST_FRAME       8'h08
`define RST_ZERO        8'h00
`define RST_PINMASK     8'h3F
`endif

// >>> verilog/uart_line_pkg.sv
// Types shared by the serial line control block.
package uart_line_pkg;
  // Transmit states, Gray coded.
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_LEAD  = 3'h1,
    TX_START = 3'h3,
    TX_DATA  = 3'h2,
    TX_PAR   = 3'h6,
    TX_STOP  = 3'h7,
    TX_TURN  = 3'h5,
    TX_BRK   = 3'h4
  } tx_state_t;
  // Receive states, Gray coded.
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h3,
    RX_PAR   = 3'h2,
    RX_STOP  = 3'h6,
    RX_BRK   = 3'h4
  } rx_state_t;
endpackage : uart_line_pkg

// >>> verilog/uart_line_ctrl.sv
// Serial line control: framing, flow, faults, break, pins.
//
// What this block does
// - Codes 7, 8, 9 set data width.
// - Parity field selects five modes.
// - Nine bits lock out parity.
// - Top frame bit: two stop bits.
// - Mode 0 none, 1 hardware, 2 software flow.
// - Mode 3: receive after match, transmit free.
// - Mode 4: receive and transmit after match.
// - Half duplex ignores receive while sending.
// - Pause symbol stops, resume restarts sending.
// - Multidrop matches against both symbols.
// - Loop bit feeds transmit to receive.
// - Break, framing, parity flags clear on read.
// - Character into full FIFO sets overrun.
// - Fault bit 7 shows live break.
// - Nonzero break register breaks after character.
// - Turnaround bit times before receive direction.
// - Pin codes 0-2: general, RTS/CTS, DTR/DSR.
// - Codes 3, 4 make pin 5 driver enable.
// - Direction bits make free pins outputs.
// - Unmasked free input change raises notification.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "uart_line_map.svh"
module uart_line_ctrl
  import uart_line_pkg::*;
#(
  parameter int CYCLES_PER_BIT = 100
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic [8:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  output logic      [8:0] rxData,
  output logic            rxValid,
  input  wire logic       rxFifoFull,
  input  wire logic       rxPin,
  output logic            txPin,
  input  wire logic [5:0] gpIn,
  output logic      [5:0] gpOut,
  output logic      [5:0] gpOe,
  input  wire logic [5:0] gpDriveLevel,
  output logic      [5:0] pinChangeBits,
  output logic            pinChangeNotify
);
  localparam int CW = 16;
  localparam logic [CW-1:0] BIT_LAST  = CW'(CYCLES_PER_BIT - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(CYCLES_PER_BIT / 2 - 1);
  if (CYCLES_PER_BIT < 4 || CYCLES_PER_BIT > 65535) begin : badBitTime
    $error("CYCLES_PER_BIT must lie between 4 and 65535");
  end

  // ==========================================================================
  // Helpers
  // Data bits of a width code; reserved codes act as eight.
  function automatic logic [3:0] dataBits(input logic [3:0] code);
    case (code)
      `WIDTH_7: dataBits = 4'h7;
      `WIDTH_9: dataBits = 4'h9;
      default:  dataBits = 4'h8;
    endcase
  endfunction : dataBits

  // Parity bit that goes with a character.
  function automatic logic parityBit(input logic [2:0] mode, input logic [8:0] d,
                                     input logic [3:0] n);
    logic x;
    x = ^(d & ((n == 4'h7) ? 9'h07F : 9'h0FF));
    case (mode)
      `PAR_ODD:  parityBit = ~x;
      `PAR_EVEN: parityBit = x;
      `PAR_MARK: parityBit = 1'b1;
      default:   parityBit = 1'b0;
    endcase
  endfunction : parityBit

  // ==========================================================================
  // Reset release and input synchronisers
  logic [1:0] rstPipe;
  logic       rst_n;
  logic [1:0] rxMeta;
  logic [5:0] gpMeta;
  logic [5:0] gpSync;
  logic [5:0] gpPrev;
  logic       rxSync;

  // Reset release and two-flop pin capture.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rst_n = rstPipe[1];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta <= 2'h3;
      gpMeta <= 6'h00;
      gpSync <= 6'h00;
      gpPrev <= 6'h00;
    end else begin
      rxMeta <= {rxMeta[0], rxPin};
      gpMeta <= gpIn;
      gpSync <= gpMeta;
      gpPrev <= gpSync;
    end
  end
  assign rxSync = rxMeta[1];

  // ==========================================================================
  // Registers
  logic [7:0] frameCfg, hsCfg, resumeSym, pauseSym, loopCtl, faults;
  logic [7:0] breakCtl, turnCfg, pinFunc, pinDir, pinMask;
  logic [7:0] next_frameCfg, next_hsCfg, next_resumeSym, next_pauseSym;
  logic [7:0] next_loopCtl, next_faults, next_breakCtl, next_turnCfg;
  logic [7:0] next_pinFunc, next_pinDir, next_pinMask, next_regRdData;
  logic       setBrk, setFrm, setPar, setOvr, breakLive;

  // Writes, read mux and read-clearing fault flags.
  always_comb begin
    next_frameCfg  = frameCfg;
    next_hsCfg     = hsCfg;
    next_resumeSym = resumeSym;
    next_pauseSym  = pauseSym;
    next_loopCtl   = loopCtl;
    next_breakCtl  = breakCtl;
    next_turnCfg   = turnCfg;
    next_pinFunc   = pinFunc;
    next_pinDir    = pinDir;
    next_pinMask   = pinMask;
    next_faults    = faults;
    next_regRdData = 8'h00;
    if (regWr) begin
      case (regAddr)
        `ADDR_FRAME: begin
          next_frameCfg = regWrData;
          if (regWrData[`FRM_WIDTH] == `WIDTH_9) begin
            next_frameCfg[`FRM_PAR] = frameCfg[`FRM_PAR];
          end
        end
        `ADDR_HANDSHAKE: next_hsCfg = {4'h0, regWrData[3:0]};
        `ADDR_RESUME:    next_resumeSym = regWrData;
        `ADDR_PAUSE:     next_pauseSym = regWrData;
        `ADDR_LOOP:      next_loopCtl = {5'h00, regWrData[`LOOP_EN], 2'h0};
        `ADDR_BREAK:     next_breakCtl = regWrData;
        `ADDR_TURN:      next_turnCfg = {4'h0, regWrData[`TURN_BITS]};
        `ADDR_PINFUNC:   next_pinFunc = {4'h0, regWrData[3:0]};
        `ADDR_PINDIR:    next_pinDir = {2'h0, regWrData[`PIN_BITS]};
        `ADDR_PINMASK:   next_pinMask = {2'h0, regWrData[`PIN_BITS]};
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        `ADDR_FRAME:     next_regRdData = frameCfg;
        `ADDR_HANDSHAKE: next_regRdData = hsCfg;
        `ADDR_RESUME:    next_regRdData = resumeSym;
        `ADDR_PAUSE:     next_regRdData = pauseSym;
        `ADDR_LOOP:      next_regRdData = loopCtl;
        `ADDR_FAULT:     next_regRdData = {breakLive, faults[6:0]};
        `ADDR_BREAK:     next_regRdData = breakCtl;
        `ADDR_TURN:      next_regRdData = turnCfg;
        `ADDR_PINFUNC:   next_regRdData = pinFunc;
        `ADDR_PINDIR:    next_regRdData = pinDir;
        `ADDR_PINMASK:   next_regRdData = pinMask;
        default:         next_regRdData = 8'h00;
      endcase
      if (regAddr == `ADDR_FAULT) begin
        next_faults = 8'h00;
      end
    end
    // A fault set while reading survives the clear.
    if (setBrk) next_faults[`FLT_BRK] = 1'b1;
    if (setFrm) next_faults[`FLT_FRM] = 1'b1;
    if (setPar) next_faults[`FLT_PAR] = 1'b1;
    if (setOvr) next_faults[`FLT_OVR] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameCfg  <= `RST_FRAME;
      hsCfg     <= `RST_ZERO;
      resumeSym <= `RST_ZERO;
      pauseSym  <= `RST_ZERO;
      loopCtl   <= `RST_ZERO;
      faults    <= `RST_ZERO;
      breakCtl  <= `RST_ZERO;
      turnCfg   <= `RST_ZERO;
      pinFunc   <= `RST_ZERO;
      pinDir    <= `RST_ZERO;
      pinMask   <= `RST_PINMASK;
      regRdData <= `RST_ZERO;
    end else begin
      frameCfg  <= next_frameCfg;
      hsCfg     <= next_hsCfg;
      resumeSym <= next_resumeSym;
      pauseSym  <= next_pauseSym;
      loopCtl   <= next_loopCtl;
      faults    <= next_faults;
      breakCtl  <= next_breakCtl;
      turnCfg   <= next_turnCfg;
      pinFunc   <= next_pinFunc;
      pinDir    <= next_pinDir;
      pinMask   <= next_pinMask;
      regRdData <= next_regRdData;
    end
  end

  // ==========================================================================
  // Decoded configuration
  logic [3:0] nBits;
  logic       hasPar, twoStop, halfDup, drvFunc, matched, paused, peerOk;
  logic [2:0] hsMode, pfCode;
  assign nBits   = dataBits(frameCfg[`FRM_WIDTH]);
  assign hasPar  = (nBits != 4'h9) && (frameCfg[`FRM_PAR] != `PAR_NONE)
                   && (frameCfg[`FRM_PAR] <= `PAR_SPACE);
  assign twoStop = frameCfg[`FRM_STOP2];
  assign hsMode  = hsCfg[`HS_MODE];
  assign halfDup = hsCfg[`HS_HALF];
  assign pfCode  = pinFunc[`PF_CODE];
  assign drvFunc = (pfCode == `PF_DRV_TX) || (pfCode == `PF_DRV_MATCH);
  // Peer ready: pin 4 or pin 2, active low.
  assign peerOk  = (pfCode == `PF_DTRDSR) ? ~gpSync[2] : ~gpSync[4];

  // ==========================================================================
  // Transmitter
  tx_state_t  txState, next_txState;
  logic [CW-1:0] txCnt, next_txCnt;
  logic [8:0] txShift, next_txShift;
  logic [3:0] txIdx, next_txIdx;
  logic       txStopIdx, next_txStopIdx, next_txPin, txAllow, txTick, txActive;
  logic       txParBit, next_txParBit;

  assign txTick   = (txCnt == '0);
  assign txActive = (txState != TX_IDLE) && (txState != TX_BRK);
  assign txAllow  = !((hsMode == `HS_SW) && paused)
                    && !((hsMode == `HS_HW) && !peerOk)
                    && !((hsMode == `HS_DROP_ALL) && !matched);
  assign txReady  = (txState == TX_IDLE) && (breakCtl == 8'h00) && txAllow;

  // Frame sequencing, turnaround and break.
  always_comb begin
    next_txState   = txState;
    next_txCnt     = txTick ? BIT_LAST : txCnt - 1'b1;
    next_txShift   = txShift;
    next_txIdx     = txIdx;
    next_txStopIdx = txStopIdx;
    next_txParBit  = txParBit;
    case (txState)
      TX_IDLE: begin
        next_txCnt = BIT_LAST;
        if (breakCtl != 8'h00) begin
          next_txState = TX_BRK;
        end else if (txValid && txReady) begin
          next_txShift  = txData;
          next_txParBit = parityBit(frameCfg[`FRM_PAR], txData, nBits);
          next_txState  = drvFunc ? TX_LEAD : TX_START;
        end
      end
      TX_LEAD:  if (txTick) next_txState = TX_START;
      TX_START: begin
        if (txTick) begin
          next_txState = TX_DATA;
          next_txIdx   = 4'h0;
        end
      end
      TX_DATA: begin
        if (txTick) begin
          next_txShift   = {1'b0, txShift[8:1]};
          next_txIdx     = txIdx + 1'b1;
          next_txStopIdx = 1'b0;
          if (txIdx == nBits - 1'b1) begin
            next_txState = hasPar ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR:   if (txTick) next_txState = TX_STOP;
      TX_STOP: begin
        if (txTick) begin
          if (twoStop && !txStopIdx) begin
            next_txStopIdx = 1'b1;
          end else if ((halfDup || drvFunc) && turnCfg[`TURN_BITS] != 4'h0) begin
            next_txState = TX_TURN;
            next_txIdx   = turnCfg[`TURN_BITS];
          end else begin
            next_txState = TX_IDLE;
          end
        end
      end
      TX_TURN: begin
        if (txTick) begin
          next_txIdx = txIdx - 1'b1;
          if (txIdx == 4'h1) next_txState = TX_IDLE;
        end
      end
      TX_BRK:   if (breakCtl == 8'h00) next_txState = TX_IDLE;
      default:  next_txState = TX_IDLE;
    endcase
    case (next_txState)
      TX_START: next_txPin = 1'b0;
      TX_DATA:  next_txPin = next_txShift[0];
      TX_PAR:   next_txPin = next_txParBit;
      TX_BRK:   next_txPin = 1'b0;
      default:  next_txPin = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txState   <= TX_IDLE;
      txCnt     <= '0;
      txShift   <= 9'h000;
      txIdx     <= 4'h0;
      txStopIdx <= 1'b0;
      txParBit  <= 1'b0;
      txPin     <= 1'b1;
    end else begin
      txState   <= next_txState;
      txCnt     <= next_txCnt;
      txShift   <= next_txShift;
      txIdx     <= next_txIdx;
      txStopIdx <= next_txStopIdx;
      txParBit  <= next_txParBit;
      txPin     <= next_txPin;
    end
  end

  // ==========================================================================
  // Receiver
  rx_state_t  rxState, next_rxState;
  logic [CW-1:0] rxCnt, next_rxCnt;
  logic [8:0] rxShift, next_rxShift, next_rxData;
  logic [3:0] rxIdx, next_rxIdx;
  logic       rxStopIdx, next_rxStopIdx, rxParErr, next_rxParErr;
  logic       next_paused, next_matched, next_rxValid, rxLine, rxTick, rxBlock;
  logic       isAddr, isSym, done;

  assign rxLine  = loopCtl[`LOOP_EN] ? txPin : rxSync;
  assign rxBlock = halfDup && txActive;
  assign rxTick  = (rxCnt == '0);
  assign breakLive = (rxState == RX_BRK);
  assign isSym   = (rxShift[7:0] == resumeSym) || (rxShift[7:0] == pauseSym);
  assign isAddr  = (nBits == 4'h9) ? rxShift[8] : !matched;

  // Mid-bit sampling, faults and delivery filter.
  always_comb begin
    next_rxState   = rxState;
    next_rxCnt     = rxTick ? BIT_LAST : rxCnt - 1'b1;
    next_rxShift   = rxShift;
    next_rxIdx     = rxIdx;
    next_rxStopIdx = rxStopIdx;
    next_rxParErr  = rxParErr;
    next_paused    = paused;
    next_matched   = matched;
    next_rxData    = rxData;
    next_rxValid   = 1'b0;
    setBrk = 1'b0;
    setFrm = 1'b0;
    setPar = 1'b0;
    setOvr = 1'b0;
    done   = 1'b0;
    case (rxState)
      RX_IDLE: begin
        next_rxCnt = HALF_LAST;
        if (!rxLine) next_rxState = RX_START;
      end
      RX_START: begin
        if (rxTick) begin
          next_rxState   = rxLine ? RX_IDLE : RX_DATA;
          next_rxIdx     = 4'h0;
          next_rxShift   = 9'h000;
          next_rxParErr  = 1'b0;
          next_rxStopIdx = 1'b0;
        end
      end
      RX_DATA: begin
        if (rxTick) begin
          next_rxShift[rxIdx] = rxLine;
          next_rxIdx = rxIdx + 1'b1;
          if (rxIdx == nBits - 1'b1) next_rxState = hasPar ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: begin
        if (rxTick) begin
          next_rxParErr = rxLine != parityBit(frameCfg[`FRM_PAR], rxShift, nBits);
          next_rxState  = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rxTick) begin
          if (!rxLine && rxShift == 9'h000) begin
            setBrk       = 1'b1;
            next_rxState = RX_BRK;
          end else if (!rxLine) begin
            setFrm       = 1'b1;
            next_rxState = RX_IDLE;
          end else if (twoStop && !rxStopIdx) begin
            next_rxStopIdx = 1'b1;
          end else begin
            done         = 1'b1;
            setPar       = rxParErr;
            next_rxState = RX_IDLE;
          end
        end
      end
      RX_BRK:  if (rxLine) next_rxState = RX_IDLE;
      default: next_rxState = RX_IDLE;
    endcase
    if (done) begin
      if (hsMode == `HS_DROP_RX || hsMode == `HS_DROP_ALL) begin
        if (isAddr) begin
          next_matched = isSym;
        end else if (matched) begin
          next_rxValid = 1'b1;
        end
      end else if (hsMode == `HS_SW && rxShift[7:0] == pauseSym) begin
        next_paused = 1'b1;
      end else if (hsMode == `HS_SW && rxShift[7:0] == resumeSym) begin
        next_paused = 1'b0;
      end else begin
        next_rxValid = 1'b1;
      end
      if (next_rxValid && rxFifoFull) begin
        next_rxValid = 1'b0;
        setOvr       = 1'b1;
      end
      if (next_rxValid) next_rxData = rxShift;
    end
    if (hsMode != `HS_SW) next_paused = 1'b0;
    if (rxBlock && rxState != RX_BRK) next_rxState = RX_IDLE;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState   <= RX_IDLE;
      rxCnt     <= '0;
      rxShift   <= 9'h000;
      rxIdx     <= 4'h0;
      rxStopIdx <= 1'b0;
      rxParErr  <= 1'b0;
      paused    <= 1'b0;
      matched   <= 1'b0;
      rxData    <= 9'h000;
      rxValid   <= 1'b0;
    end else begin
      rxState   <= next_rxState;
      rxCnt     <= next_rxCnt;
      rxShift   <= next_rxShift;
      rxIdx     <= next_rxIdx;
      rxStopIdx <= next_rxStopIdx;
      rxParErr  <= next_rxParErr;
      paused    <= next_paused;
      matched   <= next_matched;
      rxData    <= next_rxData;
      rxValid   <= next_rxValid;
    end
  end

  // ==========================================================================
  // Pins
  logic [5:0] next_gpOut, next_gpOe, taken, next_pinChangeBits;
  logic       drvOn;

  assign drvOn = (pfCode == `PF_DRV_MATCH) ? (txActive && matched) : txActive;

  // Pin takeover, direction, level and change notice.
  always_comb begin
    taken      = 6'h00;
    next_gpOe  = pinDir[`PIN_BITS];
    next_gpOut = gpDriveLevel;
    case (pfCode)
      `PF_RTSCTS: begin
        taken = 6'h30;
        next_gpOe[4] = 1'b0;
        next_gpOe[5] = 1'b1;
        next_gpOut[5] = (hsMode == `HS_HW) && rxFifoFull;
      end
      `PF_DTRDSR: begin
        taken = 6'h0C;
        next_gpOe[2] = 1'b0;
        next_gpOe[3] = 1'b1;
        next_gpOut[3] = (hsMode == `HS_HW) && rxFifoFull;
      end
      `PF_DRV_TX, `PF_DRV_MATCH: begin
        taken = 6'h20;
        next_gpOe[5] = 1'b1;
        next_gpOut[5] = pinFunc[`PF_POL] ? drvOn : ~drvOn;
      end
      default: taken = 6'h00;
    endcase
    next_pinChangeBits = (gpSync ^ gpPrev) & ~next_gpOe & ~taken & ~pinMask[`PIN_BITS];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpOut           <= 6'h00;
      gpOe            <= 6'h00;
      pinChangeBits   <= 6'h00;
      pinChangeNotify <= 1'b0;
    end else begin
      gpOut           <= next_gpOut;
      gpOe            <= next_gpOe;
      pinChangeBits   <= next_pinChangeBits;
      pinChangeNotify <= |next_pinChangeBits;
    end
  end
endmodule : uart_line_ctrl

// >>> tb/uart_line_ctrl_properties.sv
// Assertions on the serial line control ports.
`timescale 1ns/10ps
`include "uart_line_map.svh"
module uart_line_ctrl_properties (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic       txPin,
  input wire logic [5:0] gpOe,
  input wire logic [5:0] pinChangeBits,
  input wire logic       pinChangeNotify
);
  logic [7:0] shadow [0:15];
  logic [3:0] quiet;
  logic [2:0] pf;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Mirror writes; count cycles since a pin setup write.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) shadow[i] <= (i == 10) ? `RST_PINMASK : `RST_ZERO;
      quiet <= 4'h0;
    end else begin
      if (regWr) shadow[regAddr] <= regWrData;
      quiet <= (regWr && regAddr >= `ADDR_PINFUNC) ? 4'h0 : quiet + 4'(quiet != 4'hF);
    end
  end
  // Pin function code as last written.
  assign pf = shadow[`ADDR_PINFUNC][2:0];
  sequence s_take;
    txValid && txReady;
  endsequence
  property p_rd_idle; !regRd |=> regRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data stuck");
  property p_tx_start; s_take ##0 pf < 3'h3 |=> !txPin && !txReady; endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit");
  property p_idle_mark; txReady |-> txPin; endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle low");
  property p_brk_block; shadow[`ADDR_BREAK] != 8'h00 |-> !txReady; endproperty
  a_brk_block: assert property (p_brk_block) else $error("send in break");
  property p_brk_drive;
    regWr && regAddr == `ADDR_BREAK && regWrData != 8'h00 && txReady && !txValid
      |-> ##[1:3] !txPin;
  endproperty
  a_brk_drive: assert property (p_brk_drive) else $error("break not driven");
  property p_notify_or; pinChangeNotify == (|pinChangeBits); endproperty
  a_notify_or: assert property (p_notify_or) else $error("notify mismatch");
  property p_notify_mask;
    quiet > 4'h5 |-> (pinChangeBits & (shadow[`ADDR_PINMASK][5:0] | gpOe)) == 6'h00;
  endproperty
  a_notify_mask: assert property (p_notify_mask) else $error("masked notify");
  property p_dir; quiet > 4'h2 && pf == 3'h0 |-> gpOe == shadow[`ADDR_PINDIR][5:0]; endproperty
  a_dir: assert property (p_dir) else $error("bad direction");
  property p_rts; quiet > 4'h2 && pf == 3'h1 |-> gpOe[5:4] == 2'b10; endproperty
  a_rts: assert property (p_rts) else $error("flow pins wrong");
endmodule : uart_line_ctrl_properties

// >>> tb/uart_line_partner.sv
// Remote device shifting frames onto the receive line.
`timescale 1ns/10ps
module uart_line_partner #(
  parameter int CPB = 8
) (
  input  wire logic        core_clk,
  input  wire logic        go,
  input  wire logic [11:0] frame,
  input  wire logic [3:0]  len,
  output logic             rxLine
);
  // The line rests high between frames.
  initial rxLine = 1'b1;
  // Sends len frame bits, LSB first, CPB clocks each.
  always @(posedge core_clk) begin
    if (go) begin
      for (int i = 0; i < len; i++) begin
        rxLine <= frame[i];
        repeat (CPB) @(posedge core_clk);
      end
      rxLine <= 1'b1;
    end
  end
endmodule : uart_line_partner

// >>> tb/uart_line_ctrl_tb.sv
// Bench for the serial line control block.
`timescale 1ns/10ps
`include "uart_line_map.svh"
module uart_line_ctrl_tb;
  localparam int CPB = 8;
  logic        core_clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, txValid = 1'b0;
  logic        rxFifoFull = 1'b0, go = 1'b0, txReady, rxValid, rxPin, txPin, pinChangeNotify;
  logic [3:0]  regAddr = 4'h0, len = 4'h0;
  logic [7:0]  regWrData = 8'h00, regRdData;
  logic [8:0]  txData = 9'h000, rxData;
  logic [11:0] frame = 12'h000;
  logic [5:0]  gpIn = 6'h00, gpDriveLevel = 6'h00, gpOut, gpOe, pinChangeBits, seen;
  int          err_total = 0, n_checks = 0, cyc = 0;
  // Free-running core clock.
  always #5 core_clk = ~core_clk;
  uart_line_ctrl #(.CYCLES_PER_BIT(CPB)) uart_line_ctrl_i (.core_clk, .nrst, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .txData, .txValid, .txReady, .rxData, .rxValid,
    .rxFifoFull, .rxPin, .txPin, .gpIn, .gpOut, .gpOe, .gpDriveLevel, .pinChangeBits,
    .pinChangeNotify);
  uart_line_partner #(.CPB(CPB)) uart_line_partner_i (.core_clk, .go, .frame, .len,
    .rxLine(rxPin));
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask : rdc
  task automatic txc(input logic [8:0] d, input logic [14:0] e, input int n);
    @(posedge core_clk);
    txData <= d;
    txValid <= 1'b1;
    @(posedge core_clk);
    txValid <= 1'b0;
    repeat (CPB / 2) @(posedge core_clk);
    for (int j = 0; j < n; j++) begin
      #1 chk(txPin, e[j]);
      repeat (CPB) @(posedge core_clk);
    end
  endtask : txc
  task automatic rxc(input logic [8:0] e);
    for (int k = 0; k < 300 && rxValid !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk({rxValid, rxData}, {1'b1, e});
  endtask : rxc
  task automatic line(input logic [11:0] f, input logic [3:0] l, input logic [7:0] e);
    @(posedge core_clk);
    frame <= f;
    len <= l;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (13 * CPB) @(posedge core_clk);
    rdc(`ADDR_FAULT, e);
  endtask : line
  // Cut a hung run short.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(`ADDR_FRAME, `RST_FRAME);
    rdc(`ADDR_PINMASK, `RST_PINMASK);
    wr(4'hF, 8'h5A);
    rdc(4'hF, 8'h00);
    for (int m = 0; m < 5; m++) begin
      wr(`ADDR_HANDSHAKE, 8'(m) | 8'h08);
      rdc(`ADDR_HANDSHAKE, 8'(m) | 8'h08);
    end
    wr(`ADDR_HANDSHAKE, 8'h00);
    wr(`ADDR_FRAME, 8'h18);
    wr(`ADDR_FRAME, 8'h29);
    rdc(`ADDR_FRAME, 8'h19);
    $display("test registers done");
    for (int p = 0; p < 5; p++) begin
      wr(`ADDR_FRAME, {1'b0, 3'(p), 4'h8});
      txc(9'h05B, {5'h1F, p != 1 && p != 4, 8'h5B, 1'b0}, (p == 0) ? 10 : 11);
    end
    wr(`ADDR_FRAME, 8'h97);
    txc(9'h055, {7'h7F, 7'h55, 1'b0}, 11);
    wr(`ADDR_FRAME, 8'h19);
    txc(9'h1A5, {5'h1F, 9'h1A5, 1'b0}, 11);
    wr(`ADDR_BREAK, 8'h01);
    repeat (3) @(posedge core_clk);
    #1 chk({txPin, txReady}, 2'b00);
    wr(`ADDR_BREAK, 8'h00);
    repeat (3) @(posedge core_clk);
    #1 chk(txPin, 1'b1);
    $display("test transmit done");
    wr(`ADDR_FRAME, 8'h88);
    line({2'b01, 1'b0, 8'hC3, 1'b0}, 4'd11, 8'h10);
    rdc(`ADDR_FAULT, 8'h00);
    wr(`ADDR_FRAME, 8'h08);
    line(12'h000, 4'd15, 8'h88);
    repeat (40) @(posedge core_clk);
    rdc(`ADDR_FAULT, 8'h00);
    rxFifoFull <= 1'b1;
    line({3'b111, 8'h3C, 1'b0}, 4'd10, 8'h40);
    rxFifoFull <= 1'b0;
    wr(`ADDR_LOOP, 8'h04);
    txc(9'h03C, 15'h0000, 0);
    rxc(9'h03C);
    wr(`ADDR_LOOP, 8'h00);
    $display("test receive done");
    wr(`ADDR_PINDIR, 8'h15);
    wr(`ADDR_PINFUNC, 8'h01);
    repeat (3) @(posedge core_clk);
    #1 chk(gpOe, 6'h25);
    wr(`ADDR_PINFUNC, 8'h0B);
    wr(`ADDR_TURN, 8'h02);
    txc(9'h0F0, 15'h0000, 0);
    repeat (4 * CPB) @(posedge core_clk);
    #1 chk({gpOe[5], gpOut[5]}, 2'b11);
    repeat (7 * CPB) @(posedge core_clk);
    #1 chk(gpOut[5], 1'b1);
    repeat (4 * CPB) @(posedge core_clk);
    #1 chk(gpOut[5], 1'b0);
    wr(`ADDR_PINFUNC, 8'h00);
    wr(`ADDR_PINDIR, 8'h00);
    wr(`ADDR_PINMASK, 8'h3E);
    gpIn <= 6'h03;
    seen = 6'h00;
    repeat (8) begin
      @(posedge core_clk);
      #1 seen |= pinChangeBits;
    end
    chk(seen, 6'h01);
    $display("test pins done");
    final_report();
  end
endmodule : uart_line_ctrl_tb
bind uart_line_ctrl uart_line_ctrl_properties uart_line_ctrl_properties_i (.core_clk, .nrst,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData, .txValid, .txReady, .txPin, .gpOe,
  .pinChangeBits, .pinChangeNotify);
